//--- design/dsrl_dac_serial_range_loader.sv
// Overview of operation
// RULE_01 - Range command switches range and output code together on the load edge.
// RULE_02 - Cascaded parts get 32 bits each; serial output feeds next serial input.
// RULE_03 - Fourteen-bit variant uses upper 14 data bits, ignores two LSBs.
// RULE_04 - Twelve-bit variant uses upper 12 data bits, ignores four LSBs.
// RULE_05 - Frame is command, four ignored bits, 16 data bits MSB first; 1001 is 0-10V.
// RULE_06 - Command 1010 selects plus/minus 5V; bipolar codes are offset binary.
// RULE_07 - Data-only commands change the code and keep the programmed range.
// RULE_08 - Shift on rising serial clock while load is low; load rise executes.
// RULE_09 - Decode 0000, 0001, 0010, 1000 to 1101 and 1111 as specified.
// RULE_10 - Clear low zeroes every register asynchronously; later update still gives zero. Here the watchdog registers are kept through a clear.
// RULE_11 - Power-up selects 0-5V range, code 1000, and zeroes all registers.
// RULE_12 - Reserved commands leave buffers and range unchanged.
`default_nettype none
`include "dsrl_defines.svh"

module dsrl_dac_serial_range_loader
    import dsrl_pkg::*;
#(
    parameter int RES_BITS = 16,
    parameter int FIFO_DEPTH = `DSRL_FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic select_and_load_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    input wire logic async_clear_n_i,
    input wire logic update_hold_i,
    output logic load_ready_o,
    output logic frame_drop_o,
    output logic exec_pulse_o,
    output logic [3:0] range_o,
    output logic bipolar_o,
    output logic [`DSRL_DATA_BITS-1:0] input_buffer_o,
    output logic [`DSRL_DATA_BITS-1:0] dac_code_o,
    output logic [`DSRL_DATA_BITS-1:0] dac_offset_o,
    output logic range_suspect_o
);

    // Variant code widths the masking logic can serve
    if (RES_BITS != 12 && RES_BITS != 14 && RES_BITS != 16) begin : g_bad_res
        $error("dsrl: RES_BITS must be 12, 14 or 16");
    end
    if (`DSRL_CLR_WIN_CYC > 255) begin : g_bad_win
        $error("dsrl: clear window count does not fit the counter");
    end
    // The command and data fields must fit inside the shift word
    if (`DSRL_INPUT_SHIFT_REGISTER_BITS < `DSRL_CMD_MSB + 1) begin : g_bad_input_shift_register
        $error("dsrl: shift register too short for a frame");
    end

    // Bits below the variant resolution are dropped at load time
    localparam logic [`DSRL_DATA_BITS-1:0] CODE_MASK =
        `DSRL_DATA_BITS'(16'hFFFF << (`DSRL_DATA_BITS - RES_BITS)); // see RULE_03 see RULE_04
    localparam logic [7:0] CLR_WIN = 8'(`DSRL_CLR_WIN_CYC);

    // Reset image of the core: load line idle high, range at power-up value
    localparam dsrl_core_s CORE_RST = '{
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        cs_s3: 1'b1,
        pend_vld: 1'b0,
        pend: '0,
        in_buf: `DSRL_CODE_RST,
        out_buf: `DSRL_CODE_RST,
        range: `DSRL_RANGE_RST,
        bipolar: 1'b0,
        offset: `DSRL_CODE_RST ^ `DSRL_MIDSCALE,
        exec: 1'b0,
        drop: 1'b0
    }; // see RULE_11

    localparam dsrl_watch_s WATCH_RST = '{
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        cs_s3: 1'b1,
        clr_s1: 1'b1,
        clr_s2: 1'b1,
        clr_s3: 1'b1,
        win: 8'h00,
        suspect: 1'b0
    };

    dsrl_link_s l_r;
    dsrl_link_s l_nxt;
    dsrl_core_s c_r;
    dsrl_core_s c_nxt;
    dsrl_watch_s w_r;
    dsrl_watch_s w_nxt;

    logic clear_any;
    logic rst_rel1_r;
    logic rst_rel2_r;
    logic core_rst;
    logic sdo_r;
    logic load_edge;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    dsrl_frame_s fifo_out;
    logic range_cmd;
    logic hold_s1_r;
    logic hold_s2_r;

    // Clear and reset both zero the link and core state at once, without a clock
    // Limitation: clear is level driven, so noise on the pin acts at once
    assign clear_any = rst_i | ~async_clear_n_i; // see RULE_10

    // Release of the core reset is retimed to mclk so a clear that ends
    // near a clock edge cannot leave half the core out of reset
    always_ff @(posedge mclk_i or posedge clear_any) begin
        if (clear_any) begin
            rst_rel1_r <= 1'b1;
            rst_rel2_r <= 1'b1;
        end else begin
            rst_rel1_r <= 1'b0;
            rst_rel2_r <= rst_rel1_r;
        end
    end
    assign core_rst = rst_rel2_r;

    // Link domain, on the serial clock

    // Shift while the load line is low; a high load line freezes the word
    always_comb begin
        l_nxt = l_r;
        if (!select_and_load_n_i) begin
            l_nxt.input_shift_register = {l_r.input_shift_register[`DSRL_INPUT_SHIFT_REGISTER_BITS-2:0], sdi_i}; // see RULE_08 see RULE_05
        end
    end

    // The clock may stop outside frames; nothing here waits for a later edge
    // The core reads the word only after the load line has been synchronised
    always_ff @(posedge sclk_i or posedge clear_any) begin
        if (clear_any) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // Serial output changes on the falling edge so the next part in a
    // chain samples it cleanly on the shared rising edge
    always_ff @(negedge sclk_i or posedge clear_any) begin
        if (clear_any) begin
            sdo_r <= 1'b0;
        end else begin
            sdo_r <= l_r.input_shift_register[`DSRL_INPUT_SHIFT_REGISTER_BITS-1]; // see RULE_02
        end
    end
    assign sdo_o = sdo_r;

    // Core domain, on mclk

    // Load line passes two flops; the third only serves the edge detector
    // Limitation: a load pulse shorter than one mclk period may be missed
    assign load_edge = c_r.cs_s2 & ~c_r.cs_s3; // see RULE_08

    assign range_cmd = (fifo_out.cmd >= `DSRL_CMD_RANGE_FIRST) &&
                       (fifo_out.cmd <= `DSRL_CMD_RANGE_LAST);

    // Hold request comes from the analog side, off this clock, so it passes
    // two flops first; a stall that starts two cycles late only delays a frame
    always_ff @(posedge mclk_i or posedge core_rst) begin
        if (core_rst) begin
            hold_s1_r <= 1'b0;
            hold_s2_r <= 1'b0;
        end else begin
            hold_s1_r <= update_hold_i;
            hold_s2_r <= hold_s1_r;
        end
    end

    // Drain side stalls while the analog stage asks to hold updates
    assign fifo_out_ready = ~hold_s2_r;

    always_comb begin
        c_nxt = c_r;
        c_nxt.cs_s1 = select_and_load_n_i;
        c_nxt.cs_s2 = c_r.cs_s1;
        c_nxt.cs_s3 = c_r.cs_s2;
        c_nxt.exec = 1'b0;
        c_nxt.drop = 1'b0;

        // Pending frame leaves once the FIFO takes it
        if (c_r.pend_vld && fifo_in_ready) begin
            c_nxt.pend_vld = 1'b0;
        end

        // The shift word is stable here: the shift register holds while the
        // load line is high, and the edge is seen only after synchronising.
        // The host keeps the load line high until the capture is done.
        if (load_edge) begin
            if (c_nxt.pend_vld) begin
                c_nxt.drop = 1'b1; // FIFO full and slot busy: the newer frame is lost
            end else begin
                c_nxt.pend_vld = 1'b1;
                c_nxt.pend.cmd = l_r.input_shift_register[`DSRL_CMD_MSB:`DSRL_CMD_LSB]; // see RULE_05
                c_nxt.pend.data = l_r.input_shift_register[`DSRL_DATA_MSB:0] & CODE_MASK; // see RULE_03 see RULE_04
            end
        end

        // Execute one command per cycle in arrival order
        if (fifo_out_valid && fifo_out_ready) begin
            c_nxt.exec = 1'b1;
            if (fifo_out.cmd == `DSRL_CMD_LOAD_IN) begin
                c_nxt.in_buf = fifo_out.data; // see RULE_09
            end else if (fifo_out.cmd == `DSRL_CMD_UPDATE) begin
                c_nxt.out_buf = c_r.in_buf; // see RULE_09 see RULE_07 see RULE_10
            end else if (fifo_out.cmd == `DSRL_CMD_LOAD_BOTH) begin
                c_nxt.in_buf = fifo_out.data; // see RULE_07
                c_nxt.out_buf = fifo_out.data;
            end else if (range_cmd) begin
                // Range and code move in the same cycle, so no stale mix shows
                c_nxt.range = fifo_out.cmd; // see RULE_01 see RULE_05 see RULE_06
                c_nxt.in_buf = fifo_out.data; // see RULE_09
                c_nxt.out_buf = fifo_out.data; // see RULE_01
            end else begin
                // No-op and reserved codes change nothing
                c_nxt.exec = (fifo_out.cmd == `DSRL_CMD_NOP); // see RULE_12 see RULE_09
            end
        end

        // Offset binary: mid-scale is zero volts on a bipolar range
        c_nxt.bipolar = (c_nxt.range >= `DSRL_CMD_BIPOLAR_FIRST) &&
                        (c_nxt.range <= `DSRL_CMD_RANGE_LAST); // see RULE_06
        c_nxt.offset = c_nxt.out_buf ^ `DSRL_MIDSCALE; // see RULE_06
    end

    always_ff @(posedge mclk_i or posedge core_rst) begin
        if (core_rst) begin
            c_r <= CORE_RST; // see RULE_10 see RULE_11
        end else begin
            c_r <= c_nxt;
        end
    end

    // Frames waiting for execution; a full FIFO holds the pending slot
    dsrl_fifo #(
        .WIDTH($bits(dsrl_frame_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(mclk_i),
        .rst_i(core_rst),
        .in_valid_i(c_r.pend_vld),
        .in_ready_o(fifo_in_ready),
        .in_data_i(c_r.pend),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out)
    );

    // Clear-after-load watchdog

    // A clear soon after a load edge may have cut the range update short,
    // so software is told to program the range again
    always_comb begin
        w_nxt = w_r;
        w_nxt.cs_s1 = select_and_load_n_i;
        w_nxt.cs_s2 = w_r.cs_s1;
        w_nxt.cs_s3 = w_r.cs_s2;
        w_nxt.clr_s1 = async_clear_n_i;
        w_nxt.clr_s2 = w_r.clr_s1;
        w_nxt.clr_s3 = w_r.clr_s2;
        if (w_r.cs_s2 && !w_r.cs_s3) begin
            w_nxt.win = CLR_WIN;
        end else if (w_r.win != 8'h00) begin
            w_nxt.win = w_r.win - 8'h01;
        end
        // An executed command that leaves range or code off its reset value lifts the flag; a clear in the window sets it
        if (c_r.exec && (c_r.range != `DSRL_RANGE_RST || c_r.out_buf != `DSRL_CODE_RST)) begin
            w_nxt.suspect = 1'b0;
        end
        if (!w_r.clr_s2 && w_r.clr_s3 && w_r.win != 8'h00) begin
            w_nxt.suspect = 1'b1;
        end
    end

    // Only the main reset touches the watchdog, so a clear cannot wipe its own flag
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            w_r <= WATCH_RST;
        end else begin
            w_r <= w_nxt;
        end
    end

    // Outputs, all from flops except the handshake
    // Ready is combinational so a host can poll it without an extra cycle
    assign load_ready_o = fifo_in_ready;
    assign frame_drop_o = c_r.drop;
    assign exec_pulse_o = c_r.exec;
    assign range_o = c_r.range;
    assign bipolar_o = c_r.bipolar;
    assign input_buffer_o = c_r.in_buf;
    assign dac_code_o = c_r.out_buf;
    assign dac_offset_o = c_r.offset;
    assign range_suspect_o = w_r.suspect;

endmodule : dsrl_dac_serial_range_loader

`default_nettype wire

//--- design/dsrl_defines.svh
`ifndef DSRL_DEFINES_SVH
`define DSRL_DEFINES_SVH

// Frame field positions, counted in the last 24 bits shifted in
`define DSRL_INPUT_SHIFT_REGISTER_BITS 32
`define DSRL_CMD_MSB 23
`define DSRL_CMD_LSB 20
`define DSRL_DATA_MSB 15
`define DSRL_DATA_BITS 16

// Command nibble encodings
`define DSRL_CMD_LOAD_IN 4'h0
`define DSRL_CMD_UPDATE 4'h1
`define DSRL_CMD_LOAD_BOTH 4'h2
`define DSRL_CMD_RANGE_FIRST 4'h8
`define DSRL_CMD_BIPOLAR_FIRST 4'hA
`define DSRL_CMD_RANGE_LAST 4'hD
`define DSRL_CMD_NOP 4'hF

// Reset values
`define DSRL_RANGE_RST 4'h8
`define DSRL_CODE_RST 16'h0000
`define DSRL_MIDSCALE 16'h8000

// Buffering and timing
`define DSRL_FIFO_DEPTH 32
`define DSRL_MCLK_MHZ 40
`define DSRL_CLR_WIN_NS 100
`define DSRL_CLR_WIN_CYC ((`DSRL_CLR_WIN_NS * `DSRL_MCLK_MHZ + 999) / 1000)

`endif

//--- design/dsrl_pkg.sv
`default_nettype none
`include "dsrl_defines.svh"

package dsrl_pkg;

    // One executed frame: command nibble and data word
    typedef struct packed {
        logic [3:0] cmd;
        logic [`DSRL_DATA_BITS-1:0] data;
    } dsrl_frame_s;

    // Link-side state, clocked by the serial clock
    typedef struct packed {
        logic [`DSRL_INPUT_SHIFT_REGISTER_BITS-1:0] input_shift_register;
    } dsrl_link_s;

    // Core state, zeroed by reset and by the clear pin
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic pend_vld;
        dsrl_frame_s pend;
        logic [`DSRL_DATA_BITS-1:0] in_buf;
        logic [`DSRL_DATA_BITS-1:0] out_buf;
        logic [3:0] range;
        logic bipolar;
        logic [`DSRL_DATA_BITS-1:0] offset;
        logic exec;
        logic drop;
    } dsrl_core_s;

    // Watchdog state, touched by reset only so it survives a clear
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic clr_s1;
        logic clr_s2;
        logic clr_s3;
        logic [7:0] win;
        logic suspect;
    } dsrl_watch_s;

endpackage : dsrl_pkg

`default_nettype wire

//--- design/dsrl_fifo.sv
`default_nettype none
`include "dsrl_defines.svh"

module dsrl_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = `DSRL_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } dsrl_fifo_s;

    dsrl_fifo_s f_r;
    dsrl_fifo_s f_nxt;
    logic full;
    logic empty;

    // Pointers carry one extra wrap bit so full and empty differ
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("dsrl_fifo: DEPTH must be a power of two, at least 2");
    end

    // Honest flags straight from the pointers
    assign empty = (f_r.wp == f_r.rp);
    assign full = (f_r.wp[AW-1:0] == f_r.rp[AW-1:0]) && (f_r.wp[AW] != f_r.rp[AW]);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = f_r.mem[f_r.rp[AW-1:0]];

    // Write and read may happen in the same cycle
    always_comb begin
        f_nxt = f_r;
        if (in_valid_i && !full) begin
            f_nxt.mem[f_r.wp[AW-1:0]] = in_data_i;
            f_nxt.wp = f_r.wp + 1'b1;
        end
        if (out_ready_i && !empty) begin
            f_nxt.rp = f_r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            f_r <= '0;
        end else begin
            f_r <= f_nxt;
        end
    end

endmodule : dsrl_fifo

`default_nettype wire

//--- tb/dsrl_props.sv
`default_nettype none
`include "dsrl_defines.svh"

module dsrl_props
    import dsrl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic select_and_load_n_i,
    input wire logic sdi_i,
    input wire logic sdo_o,
    input wire logic async_clear_n_i,
    input wire logic update_hold_i,
    input wire logic load_ready_o,
    input wire logic frame_drop_o,
    input wire logic exec_pulse_o,
    input wire logic [3:0] range_o,
    input wire logic bipolar_o,
    input wire logic [`DSRL_DATA_BITS-1:0] input_buffer_o,
    input wire logic [`DSRL_DATA_BITS-1:0] dac_code_o,
    input wire logic [`DSRL_DATA_BITS-1:0] dac_offset_o,
    input wire logic range_suspect_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] shadow_r;

    // Mirror of the link shift register; cleared by both resets like the device's own
    always_ff @(posedge sclk_i or posedge rst_i or negedge async_clear_n_i) begin
        if (rst_i || !async_clear_n_i) begin
            shadow_r <= 32'h0000_0000;
        end else if (!select_and_load_n_i) begin
            shadow_r <= {shadow_r[30:0], sdi_i};
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // Reset checks cannot be disabled by the reset they watch
    a_reset_state: assert property (disable iff (1'b0) rst_i |-> range_o == 4'h8 && dac_code_o == 16'h0000 && input_buffer_o == 16'h0000) else $error("reset state wrong");
    a_reset_flags: assert property (disable iff (1'b0) rst_i |-> load_ready_o && !exec_pulse_o && !frame_drop_o && !range_suspect_o) else $error("reset flags wrong");
    a_clear_zero: assert property (!async_clear_n_i |=> range_o == 4'h8 && dac_code_o == 16'h0000 && input_buffer_o == 16'h0000) else $error("clear did not zero");
    a_bipolar_map: assert property (bipolar_o == (range_o inside {[4'hA:4'hD]})) else $error("bipolar flag mismatch");
    a_offset_view: assert property (dac_offset_o == (dac_code_o ^ 16'h8000)) else $error("offset view wrong");
    a_range_legal: assert property (range_o inside {[4'h8:4'hD]}) else $error("range code illegal");
    a_change_needs_exec: assert property (disable iff (rst_i || !async_clear_n_i) (range_o != $past(range_o) || dac_code_o != $past(dac_code_o) || input_buffer_o != $past(input_buffer_o)) |-> exec_pulse_o) else $error("state changed without exec");
    a_sdo_shift: assert property (@(posedge sclk_i) disable iff (rst_i || !async_clear_n_i) !select_and_load_n_i |-> sdo_o == shadow_r[31]) else $error("serial out wrong");

    cover property (exec_pulse_o && bipolar_o);
    cover property (frame_drop_o);
    cover property ($rose(range_suspect_o));
    cover property ($rose(select_and_load_n_i) ##[1:10] exec_pulse_o);
endmodule : dsrl_props

bind dsrl_dac_serial_range_loader dsrl_props i_dsrl_props (.*);

`default_nettype wire

//--- tb/dsrl_host_model.sv
`default_nettype none

module dsrl_host_model (
    output var logic sclk_o,
    output var logic select_and_load_n_o,
    output var logic sdi_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link idles with clock stopped low and select high
    initial begin
        sclk_o = 1'b0;
        select_and_load_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // Shifts the low n bits of f MSB first; the clock only runs inside the frame
    task automatic send(input logic [31:0] f, input int n);
        select_and_load_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi_o = f[i];
            #7.5 sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
        end
        // Released data line shows the inverse, so a stale bit cannot pass
        sdi_o = ~sdi_o;
        #7.5 select_and_load_n_o = 1'b1;
    endtask : send
endmodule : dsrl_host_model

`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
`include "dsrl_defines.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; $display("FAIL %s exp %h got %h", nm, exp, got); end end

module tb_top
    import dsrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk_i, rst_i, async_clear_n_i, update_hold_i, sclk_i, select_and_load_n_i, sdi_i;
    logic sdo_o, load_ready_o, frame_drop_o, exec_pulse_o, bipolar_o, range_suspect_o;
    logic [3:0] range_o;
    logic [15:0] input_buffer_o, dac_code_o, dac_offset_o;
    int error_cnt = 0;
    int cmp_count = 0;
    int exec_cnt = 0;
    int drop_cnt = 0;
    int k, e0;
    logic [3:0] rsv [6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hE};

    dsrl_dac_serial_range_loader i_dsrl_dac_serial_range_loader (.*);
    dsrl_host_model i_dsrl_host_model (.sclk_o(sclk_i), .select_and_load_n_o(select_and_load_n_i), .sdi_o(sdi_i));

    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // Pulse counters, so single-cycle outputs are never missed
    always @(posedge mclk_i) begin
        if (exec_pulse_o === 1'b1) exec_cnt++;
        if (frame_drop_o === 1'b1) drop_cnt++;
    end

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // One frame, then enough idle for execution and the select-high gap
    task automatic frame(input logic [31:0] f, input int n);
        @(posedge mclk_i);
        #1;
        i_dsrl_host_model.send(f, n);
        repeat (12) @(posedge mclk_i);
        #1;
    endtask : frame

    task automatic expect_state(input logic [3:0] r, input logic [15:0] c, input logic [15:0] b);
        `CHK("range", r, range_o)
        `CHK("code", c, dac_code_o)
        `CHK("inbuf", b, input_buffer_o)
    endtask : expect_state

    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        rst_i = 1'b1;
        async_clear_n_i = 1'b1;
        update_hold_i = 1'b0;
        repeat (4) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        expect_state(4'h8, 16'h0000, 16'h0000);
        `CHK("suspect", 1'b0, range_suspect_o)
        `CHK("bipolar", 1'b0, bipolar_o)
        frame(32'h0090_0000, 24);
        expect_state(4'h9, 16'h0000, 16'h0000);
        frame(32'h00A0_8000, 24);
        expect_state(4'hA, 16'h8000, 16'h8000);
        `CHK("offset", 16'h0000, dac_offset_o)
        frame(32'hFFB0_C000, 32);
        expect_state(4'hB, 16'hC000, 16'hC000);
        frame(32'h000F_1234, 24);
        expect_state(4'hB, 16'hC000, 16'h1234);
        frame(32'h0010_0000, 24);
        expect_state(4'hB, 16'h1234, 16'h1234);
        frame(32'h0020_5678, 24);
        expect_state(4'hB, 16'h5678, 16'h5678);
        for (int c = 8; c <= 13; c++) begin
            frame({8'h00, 4'(c), 4'h0, 4'(c), 12'h321}, 24);
            expect_state(4'(c), {4'(c), 12'h321}, {4'(c), 12'h321});
        end
        // Reserved codes must be silent, NOP still pulses exec
        for (int i = 0; i < 6; i++) begin
            e0 = exec_cnt;
            frame({8'h00, rsv[i], 4'h0, 16'hBEEF}, 24);
            expect_state(4'hD, 16'hD321, 16'hD321);
            `CHK("exec", e0, exec_cnt)
        end
        e0 = exec_cnt;
        frame(32'h00F0_BEEF, 24);
        expect_state(4'hD, 16'hD321, 16'hD321);
        `CHK("exec", e0 + 1, exec_cnt)
        @(posedge mclk_i);
        #1 async_clear_n_i = 1'b0;
        @(posedge mclk_i);
        #1 async_clear_n_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        expect_state(4'h8, 16'h0000, 16'h0000);
        `CHK("suspect", 1'b0, range_suspect_o)
        frame(32'h0010_0000, 24);
        expect_state(4'h8, 16'h0000, 16'h0000);
        // Clear soon after a load edge: frame lost, range must be reloaded
        @(posedge mclk_i);
        #1;
        i_dsrl_host_model.send(32'h0090_0000, 24);
        repeat (2) @(posedge mclk_i);
        #1 async_clear_n_i = 1'b0;
        @(posedge mclk_i);
        #1 async_clear_n_i = 1'b1;
        repeat (6) @(posedge mclk_i);
        #1;
        expect_state(4'h8, 16'h0000, 16'h0000);
        `CHK("suspect", 1'b1, range_suspect_o)
        frame(32'h00A0_8000, 24);
        expect_state(4'hA, 16'h8000, 16'h8000);
        `CHK("bipolar", 1'b1, bipolar_o)
        `CHK("suspect", 1'b0, range_suspect_o)
        // Fill the queue while execution stalls, overflow it once, then drain
        update_hold_i = 1'b1;
        k = 0;
        while (load_ready_o === 1'b1 && k < 40) begin
            frame({16'h0020, 16'(k)}, 24);
            k++;
        end
        `CHK("depth", 32, k)
        frame({16'h0020, 16'(k)}, 24);
        frame({16'h0020, 16'(k + 1)}, 24);
        `CHK("drops", 1, drop_cnt)
        e0 = exec_cnt;
        update_hold_i = 1'b0;
        repeat (200) @(posedge mclk_i);
        #1;
        `CHK("drained", 33, exec_cnt - e0)
        `CHK("code", 16'(32), dac_code_o)
        `CHK("ready", 1'b1, load_ready_o)
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
